//--- sfw_consts.svh
// register addresses, field positions, reset values and mode codes for
// the register access firewall; include wherever these names are needed
// Behaviour
// - copy run keeps mode and segment right latched at start
// - shared CPU registers open in all modes
// - duplicated subset only in System/User
// - control-status readable in Firmware and User
// - clock select readable in Firmware always
// - segment size readable in Firmware
// - segmentation registers only in System mode
// - firewall config writes refused in Firmware
// - segment table pointer never reads back
// - random result register is read-only
// - cipher key registers never read back
// - full-duplex copy engine fully blocked
// - exchange windows set only from System
// - Firmware flash access needs System grant
// - System changes table pointer, User cannot
// - segmentation registers reset to zero
// - security writes need mode write permission
// - mode changes on control-status write
// - mode changes on entry vector calls
// - mode changes on special call targets
// - exceptions enter, return restores mode
`ifndef SFW_CONSTS_SVH
`define SFW_CONSTS_SVH
// register groups, upper nibble of the register address
`define SFW_GRP_GEN 4'h0
`define SFW_GRP_DUP 4'h1
`define SFW_GRP_SYSM 4'h2
`define SFW_GRP_HW 4'h3
`define SFW_GRP_SEG 4'h4
`define SFW_GRP_FWC 4'h5
`define SFW_GRP_TST 4'h6
`define SFW_GRP_FWOS 4'h7
// registers held in this block
`define SFW_A_CSR 8'h20
`define SFW_A_TPTR 8'h21
`define SFW_A_SEGPTR 8'h40
`define SFW_A_SEGEN 8'h41
`define SFW_A_FWL 8'h50
`define SFW_A_FWH 8'h51
`define SFW_A_XBASE 8'h52
`define SFW_A_XSIZE 8'h53
`define SFW_A_FGRANT 8'h54
`define SFW_A_ESIZE 8'h60
// special registers of other blocks
`define SFW_A_CLKSEL 8'h30
`define SFW_A_RNG 8'h31
`define SFW_KEY_MSB 5'h07
// control-status mode field and flash grant bit
`define SFW_CSR_MODE_LSB 0
`define SFW_CSR_MODE_MSB 2
`define SFW_FGRANT_BIT 0
// mode codes in the mode field
`define SFW_CODE_BOOT 3'h0
`define SFW_CODE_TEST 3'h1
`define SFW_CODE_FW 3'h2
`define SFW_CODE_SYS 3'h3
`define SFW_CODE_USER 3'h4
// reset values
`define SFW_RST_REG8 8'h00
`define SFW_RST_DATA32 32'h0000_0000
// access sources
`define SFW_SRC_CPU 2'h0
`define SFW_SRC_COPY 2'h1
`define SFW_SRC_FDCOPY 2'h2
`endif

//--- sfw_pkg.sv
// types for the register access firewall
// assumes sfw_consts.svh for numeric values
package sfw_pkg;
   typedef enum logic [4:0] {
      SFW_BOOT = 5'b00001,
      SFW_TEST = 5'b00010,
      SFW_FW = 5'b00100,
      SFW_SYS = 5'b01000,
      SFW_USER = 5'b10000
   } sfw_mode_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [1:0] src;
      logic [7:0] addr;
      logic [7:0] rdata;
      logic seg_right;
   } sfw_chk_req_t;

   typedef struct packed {
      logic done;
      logic grant;
      logic we;
      logic [7:0] rdata;
   } sfw_chk_rsp_t;

   typedef struct packed {
      logic system_entry_vector;
      logic firmware_entry_vector;
      logic call;
      logic [2:0] call_code;
      logic exc;
      logic return_from_interrupt;
   } sfw_mode_evt_t;
endpackage

//--- sfw_top.sv
// register access firewall: holds the CPU mode and the security registers,
// answers Avalon-MM for its own registers and judges other accesses
// assumes one clock, synchronous inputs, mode events as one-cycle pulses
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "sfw_consts.svh"
module sfw_top (
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic CE_IN,
   input wire logic [7:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   input wire logic [3:0] AVS_BYTEENABLE_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   input wire logic SEG_RIGHT_IN,
   input wire sfw_pkg::sfw_chk_req_t CHK_REQ_IN,
   output sfw_pkg::sfw_chk_rsp_t CHK_RSP_OUT,
   input wire logic CPY_START_IN,
   input wire logic CPY_END_IN,
   input wire sfw_pkg::sfw_mode_evt_t EVT_IN,
   output sfw_pkg::sfw_mode_t MODE_OUT,
   output logic [7:0] SEG_PTR_OUT,
   output logic [7:0] SEG_EN_OUT,
   output logic [7:0] SEG_SIZE_OUT,
   output logic [7:0] XCHG_BASE_OUT,
   output logic [7:0] XCHG_SIZE_OUT,
   output logic FW_FLASH_OK_OUT
);
   sfw_pkg::sfw_mode_t mode_r;
   sfw_pkg::sfw_mode_t mode_nxt;
   sfw_pkg::sfw_mode_t saved_mode_r;
   sfw_pkg::sfw_mode_t copy_mode_r;
   logic copy_seg_r;
   logic copy_busy_r;
   logic [7:0] tptr_r;
   logic [7:0] seg_ptr_r;
   logic [7:0] seg_en_r;
   logic [7:0] fwl_r;
   logic [7:0] fwh_r;
   logic [7:0] xbase_r;
   logic [7:0] xsize_r;
   logic [7:0] fgrant_r;
   logic [7:0] esize_r;
   logic [15:0] fw_rights;
   logic av_req;
   logic av_take;
   logic av_rd_ok;
   logic av_wr_ok;
   logic [7:0] av_rdata;
   logic [7:0] av_wdata;
   logic csr_wr;
   sfw_pkg::sfw_mode_t chk_mode;
   logic chk_seg;
   logic chk_ok;

   function automatic sfw_pkg::sfw_mode_t code2mode(input logic [2:0] c);
      case (c)
         `SFW_CODE_BOOT: code2mode = sfw_pkg::SFW_BOOT;
         `SFW_CODE_TEST: code2mode = sfw_pkg::SFW_TEST;
         `SFW_CODE_FW: code2mode = sfw_pkg::SFW_FW;
         `SFW_CODE_SYS: code2mode = sfw_pkg::SFW_SYS;
         default: code2mode = sfw_pkg::SFW_USER;
      endcase
   endfunction

   function automatic logic [2:0] mode2code(input sfw_pkg::sfw_mode_t m);
      case (m)
         sfw_pkg::SFW_BOOT: mode2code = `SFW_CODE_BOOT;
         sfw_pkg::SFW_TEST: mode2code = `SFW_CODE_TEST;
         sfw_pkg::SFW_FW: mode2code = `SFW_CODE_FW;
         sfw_pkg::SFW_SYS: mode2code = `SFW_CODE_SYS;
         default: mode2code = `SFW_CODE_USER;
      endcase
   endfunction

   // the one access decision, shared by the bus and the check port
   function automatic logic allow(
      input sfw_pkg::sfw_mode_t m,
      input logic [7:0] a,
      input logic wr,
      input logic [15:0] rights,
      input logic seg
   );
      logic rd;
      logic boot;
      logic test;
      logic fw;
      logic sys;
      logic usr;
      logic ok;
      rd = ~wr;
      boot = (m == sfw_pkg::SFW_BOOT);
      test = (m == sfw_pkg::SFW_TEST);
      fw = (m == sfw_pkg::SFW_FW);
      sys = (m == sfw_pkg::SFW_SYS);
      usr = (m == sfw_pkg::SFW_USER);
      case (a[7:4])
         `SFW_GRP_GEN: ok = 1'b1;
         `SFW_GRP_DUP: ok = sys | usr;
         `SFW_GRP_SYSM: begin
            ok = boot | test | sys;
            if (rd && a == `SFW_A_CSR && (fw || usr)) begin
               ok = 1'b1;
            end
            if (rd && a == `SFW_A_TPTR) begin
               ok = 1'b0;
            end
         end
         `SFW_GRP_HW: begin
            ok = boot | test | sys | (fw & rights[a[3:0]]) | (usr & seg);
            if (rd && fw && a == `SFW_A_CLKSEL) begin
               ok = 1'b1;
            end
            if (wr && a == `SFW_A_RNG) begin
               ok = 1'b0;
            end
            if (rd && a[7:3] == `SFW_KEY_MSB) begin
               ok = 1'b0;
            end
         end
         `SFW_GRP_SEG: ok = sys;
         `SFW_GRP_FWC: ok = boot | test | sys | (fw & rd);
         `SFW_GRP_TST: begin
            ok = test;
            if (rd && fw && a == `SFW_A_ESIZE) begin
               ok = 1'b1;
            end
         end
         `SFW_GRP_FWOS: ok = boot | test | fw;
         default: ok = 1'b0;
      endcase
      allow = ok;
   endfunction

   assign fw_rights = {fwh_r, fwl_r};
   assign av_req = AVS_READ_IN | AVS_WRITE_IN;
   // one wait state: request taken while waitrequest is still high
   assign av_take = CE_IN & av_req & AVS_WAITREQUEST_OUT;
   assign av_wdata = AVS_WRITEDATA_IN[7:0];
   assign av_rd_ok = allow(mode_r, AVS_ADDRESS_IN, 1'b0, fw_rights,
                           SEG_RIGHT_IN);
   // exchange windows and flash grant are stricter than their group
   assign av_wr_ok = AVS_WRITE_IN & AVS_BYTEENABLE_IN[0] &
      allow(mode_r, AVS_ADDRESS_IN, 1'b1, fw_rights, SEG_RIGHT_IN) &
      ((AVS_ADDRESS_IN != `SFW_A_XBASE && AVS_ADDRESS_IN != `SFW_A_XSIZE &&
        AVS_ADDRESS_IN != `SFW_A_FGRANT) ||
       mode_r == sfw_pkg::SFW_SYS);
   assign csr_wr = av_take & av_wr_ok & (AVS_ADDRESS_IN == `SFW_A_CSR);

   always_comb begin
      case (AVS_ADDRESS_IN)
         `SFW_A_CSR: av_rdata = {5'h00, mode2code(mode_r)};
         `SFW_A_SEGPTR: av_rdata = seg_ptr_r;
         `SFW_A_SEGEN: av_rdata = seg_en_r;
         `SFW_A_FWL: av_rdata = fwl_r;
         `SFW_A_FWH: av_rdata = fwh_r;
         `SFW_A_XBASE: av_rdata = xbase_r;
         `SFW_A_XSIZE: av_rdata = xsize_r;
         `SFW_A_FGRANT: av_rdata = fgrant_r;
         `SFW_A_ESIZE: av_rdata = esize_r;
         default: av_rdata = `SFW_RST_REG8;
      endcase
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         AVS_WAITREQUEST_OUT <= 1'b1;
         AVS_READDATA_OUT <= `SFW_RST_DATA32;
      end else if (CE_IN) begin
         AVS_WAITREQUEST_OUT <= ~(av_req & AVS_WAITREQUEST_OUT);
         if (av_take && AVS_READ_IN) begin
            // refused or unmapped reads give zero
            AVS_READDATA_OUT <= av_rd_ok ?
               {24'h000000, av_rdata} : `SFW_RST_DATA32;
         end
      end
   end

   // security registers; refused writes simply do not load
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         seg_ptr_r <= `SFW_RST_REG8;
         seg_en_r <= `SFW_RST_REG8;
         esize_r <= `SFW_RST_REG8;
         tptr_r <= `SFW_RST_REG8;
         fwl_r <= `SFW_RST_REG8;
         fwh_r <= `SFW_RST_REG8;
         xbase_r <= `SFW_RST_REG8;
         xsize_r <= `SFW_RST_REG8;
         fgrant_r <= `SFW_RST_REG8;
      end else if (av_take && av_wr_ok) begin
         case (AVS_ADDRESS_IN)
            `SFW_A_SEGPTR: seg_ptr_r <= av_wdata;
            `SFW_A_SEGEN: seg_en_r <= av_wdata;
            `SFW_A_ESIZE: esize_r <= av_wdata;
            `SFW_A_TPTR: tptr_r <= av_wdata;
            `SFW_A_FWL: fwl_r <= av_wdata;
            `SFW_A_FWH: fwh_r <= av_wdata;
            `SFW_A_XBASE: xbase_r <= av_wdata;
            `SFW_A_XSIZE: xsize_r <= av_wdata;
            `SFW_A_FGRANT: fgrant_r <= av_wdata;
            default: ;
         endcase
      end
   end

   // mode changes; hardware events outrank a register write
   always_comb begin
      mode_nxt = mode_r;
      if (EVT_IN.exc) begin
         mode_nxt = sfw_pkg::SFW_SYS;
      end else if (EVT_IN.return_from_interrupt) begin
         mode_nxt = saved_mode_r;
      end else if (EVT_IN.system_entry_vector) begin
         mode_nxt = sfw_pkg::SFW_SYS;
      end else if (EVT_IN.firmware_entry_vector) begin
         mode_nxt = sfw_pkg::SFW_FW;
      end else if (EVT_IN.call) begin
         mode_nxt = code2mode(EVT_IN.call_code);
      end else if (csr_wr) begin
         mode_nxt = code2mode(av_wdata[`SFW_CSR_MODE_MSB:`SFW_CSR_MODE_LSB]);
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         mode_r <= sfw_pkg::SFW_BOOT;
         saved_mode_r <= sfw_pkg::SFW_BOOT;
      end else if (CE_IN) begin
         mode_r <= mode_nxt;
         if (EVT_IN.exc) begin
            // single level only: nested entries overwrite the saved mode
            saved_mode_r <= mode_r;
         end
      end
   end

   // copy engine mode and segment right frozen at launch
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         copy_mode_r <= sfw_pkg::SFW_BOOT;
         copy_seg_r <= 1'b0;
         copy_busy_r <= 1'b0;
      end else if (CE_IN) begin
         if (CPY_START_IN) begin
            copy_mode_r <= mode_r;
            copy_seg_r <= SEG_RIGHT_IN;
            copy_busy_r <= 1'b1;
         end else if (CPY_END_IN) begin
            copy_busy_r <= 1'b0;
         end
      end
   end

   always_comb begin
      chk_mode = mode_r;
      chk_seg = CHK_REQ_IN.seg_right;
      if (CHK_REQ_IN.src == `SFW_SRC_COPY) begin
         chk_mode = copy_mode_r;
         chk_seg = copy_seg_r;
      end
   end

   assign chk_ok = allow(chk_mode, CHK_REQ_IN.addr, CHK_REQ_IN.write,
                         fw_rights, chk_seg) &
      (CHK_REQ_IN.src != `SFW_SRC_FDCOPY) &
      (CHK_REQ_IN.src != `SFW_SRC_COPY || copy_busy_r);

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         CHK_RSP_OUT <= '0;
      end else if (CE_IN) begin
         CHK_RSP_OUT.done <= CHK_REQ_IN.valid;
         CHK_RSP_OUT.grant <= CHK_REQ_IN.valid & chk_ok;
         CHK_RSP_OUT.we <= CHK_REQ_IN.valid & chk_ok & CHK_REQ_IN.write;
         CHK_RSP_OUT.rdata <= (CHK_REQ_IN.valid && chk_ok &&
            !CHK_REQ_IN.write) ? CHK_REQ_IN.rdata : `SFW_RST_REG8;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         MODE_OUT <= sfw_pkg::SFW_BOOT;
         SEG_PTR_OUT <= `SFW_RST_REG8;
         SEG_EN_OUT <= `SFW_RST_REG8;
         SEG_SIZE_OUT <= `SFW_RST_REG8;
         XCHG_BASE_OUT <= `SFW_RST_REG8;
         XCHG_SIZE_OUT <= `SFW_RST_REG8;
         FW_FLASH_OK_OUT <= 1'b0;
      end else if (CE_IN) begin
         MODE_OUT <= mode_nxt;
         SEG_PTR_OUT <= seg_ptr_r;
         SEG_EN_OUT <= seg_en_r;
         SEG_SIZE_OUT <= esize_r;
         XCHG_BASE_OUT <= xbase_r;
         XCHG_SIZE_OUT <= xsize_r;
         FW_FLASH_OK_OUT <= fgrant_r[`SFW_FGRANT_BIT] &
            (mode_nxt == sfw_pkg::SFW_FW);
      end
   end
endmodule

//--- sfw_cpu_mdl.sv
// model of the CPU core and copy engines issuing register checks
// assumes the bench raises issue_in for one cycle per request
`timescale 1ns/1ps
module sfw_cpu_mdl (
   input wire logic clk_in,
   input wire logic issue_in,
   input wire logic wr_in,
   input wire logic [1:0] src_in,
   input wire logic [7:0] addr_in,
   output sfw_pkg::sfw_chk_req_t req_out
);
   always_ff @(posedge clk_in) begin
      req_out.valid <= issue_in;
      req_out.write <= wr_in;
      req_out.src <= src_in;
      req_out.addr <= addr_in;
      req_out.seg_right <= 1'b0;
      // idle data flips so a stale byte never looks live
      req_out.rdata <= issue_in ? addr_in ^ 8'ha5 : ~req_out.rdata;
   end
endmodule

//--- sfw_top_chk.sv
// port checker for the register access firewall
// assumes one clock domain, bound to sfw_top
`timescale 1ns/1ps
module sfw_top_chk (
   input wire logic CLK_IN,
   input wire logic RST_IN,
   input wire logic CE_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic AVS_WAITREQUEST_OUT,
   input wire sfw_pkg::sfw_chk_req_t CHK_REQ_IN,
   input wire sfw_pkg::sfw_chk_rsp_t CHK_RSP_OUT,
   input wire sfw_pkg::sfw_mode_evt_t EVT_IN,
   input wire sfw_pkg::sfw_mode_t MODE_OUT,
   input wire logic [7:0] SEG_PTR_OUT,
   input wire logic [7:0] SEG_EN_OUT
);
   logic [1:0] busy_r;
   // mode output loads mode_nxt in step with the internal mode; requests near a change are still skipped
   always_ff @(posedge CLK_IN)
      busy_r <= {busy_r[0], (|EVT_IN) | AVS_WRITE_IN};
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);
   sequence av_req_s;
      (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT && CE_IN;
   endsequence
   sequence cpu_req_s;
      CE_IN && CHK_REQ_IN.valid && CHK_REQ_IN.src == 2'h0 && busy_r == 2'h0;
   endsequence
   wait_one_a: assert property (av_req_s |=> !AVS_WAITREQUEST_OUT ##1
      AVS_WAITREQUEST_OUT) else $error("waitrequest not one cycle");
   done_next_a: assert property (CE_IN && CHK_REQ_IN.valid |=>
      CHK_RSP_OUT.done) else $error("check answer late");
   fd_block_a: assert property (CE_IN && CHK_REQ_IN.valid &&
      CHK_REQ_IN.src == 2'h2 |=> !CHK_RSP_OUT.grant && !CHK_RSP_OUT.we)
      else $error("full-duplex copy granted");
   key_hide_a: assert property (CE_IN && CHK_REQ_IN.valid &&
      !CHK_REQ_IN.write && CHK_REQ_IN.addr[7:3] == 5'h07 |=>
      CHK_RSP_OUT.rdata == 8'h00) else $error("key readable");
   rng_ro_a: assert property (CE_IN && CHK_REQ_IN.valid &&
      CHK_REQ_IN.write && CHK_REQ_IN.addr == 8'h31 |=> !CHK_RSP_OUT.we)
      else $error("random result written");
   seg_sys_a: assert property (cpu_req_s ##0
      (CHK_REQ_IN.addr[7:4] == 4'h4 && MODE_OUT != sfw_pkg::SFW_SYS)
      |=> !CHK_RSP_OUT.grant) else $error("segment reg open");
   dup_mode_a: assert property (cpu_req_s ##0
      (CHK_REQ_IN.addr[7:4] == 4'h1 && MODE_OUT inside {sfw_pkg::SFW_BOOT,
      sfw_pkg::SFW_TEST, sfw_pkg::SFW_FW}) |=> !CHK_RSP_OUT.grant)
      else $error("duplicate reg open");
   deny_zero_a: assert property (CHK_RSP_OUT.done &&
      !CHK_RSP_OUT.grant |-> CHK_RSP_OUT.rdata == 8'h00)
      else $error("refused read not zero");
   seg_reset_a: assert property (disable iff (1'b0) RST_IN ##1 RST_IN |=>
      SEG_PTR_OUT == 8'h00 && SEG_EN_OUT == 8'h00 &&
      MODE_OUT == sfw_pkg::SFW_BOOT) else $error("reset values wrong");
endmodule
bind sfw_top sfw_top_chk sfw_top_chk_inst (.CLK_IN(CLK_IN),
   .RST_IN(RST_IN), .CE_IN(CE_IN), .AVS_READ_IN(AVS_READ_IN),
   .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
   .CHK_REQ_IN(CHK_REQ_IN), .CHK_RSP_OUT(CHK_RSP_OUT), .EVT_IN(EVT_IN),
   .MODE_OUT(MODE_OUT), .SEG_PTR_OUT(SEG_PTR_OUT), .SEG_EN_OUT(SEG_EN_OUT));

//--- test_sfw_top.sv
// self-checking bench for the register access firewall
// assumes sfw_top, sfw_cpu_mdl and the bound checker
`timescale 1ns/1ps
module test_sfw_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wd = 32'h0000_0000;
   logic [31:0] rdat, q;
   logic wq, fok, iss = 1'b0, iwr = 1'b0, cst = 1'b0, cen = 1'b0;
   logic [1:0] isrc = 2'h0;
   logic [7:0] iadr = 8'h00;
   logic [7:0] segp, xb, ssz, xsz;
   sfw_pkg::sfw_mode_evt_t evt = '0;
   sfw_pkg::sfw_chk_req_t req;
   sfw_pkg::sfw_chk_rsp_t rsp;
   sfw_pkg::sfw_mode_t mode;
   int mismatches = 0;
   int n_checks = 0;
   int cyc = 0;
   always #5 clk = ~clk;
   sfw_top sfw_top_inst (.CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1),
      .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
      .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hf),
      .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wq),
      .SEG_RIGHT_IN(1'b0), .CHK_REQ_IN(req), .CHK_RSP_OUT(rsp),
      .CPY_START_IN(cst), .CPY_END_IN(cen), .EVT_IN(evt),
      .MODE_OUT(mode), .SEG_PTR_OUT(segp), .SEG_EN_OUT(),
      .SEG_SIZE_OUT(ssz), .XCHG_BASE_OUT(xb), .XCHG_SIZE_OUT(xsz),
      .FW_FLASH_OK_OUT(fok));
   sfw_cpu_mdl sfw_cpu_mdl_inst (.clk_in(clk), .issue_in(iss),
      .wr_in(iwr), .src_in(isrc), .addr_in(iadr), .req_out(req));
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         wrap_up();
      end
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic av(input logic w, input logic [7:0] a, input logic [7:0] d);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= {24'h0, d};
      do
         @(posedge clk);
      while (wq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   // rsp is looked at in the one cycle it stands
   task automatic ck(input logic [1:0] s, input logic w, input logic [7:0] a);
      iss <= 1'b1;
      isrc <= s;
      iwr <= w;
      iadr <= a;
      @(posedge clk);
      iss <= 1'b0;
      @(posedge clk);
      // answer launched one edge back is still held here
      @(posedge clk);
   endtask
   task automatic ev(input sfw_pkg::sfw_mode_evt_t e);
      evt <= e;
      @(posedge clk);
      evt <= '0;
      repeat (2) @(posedge clk);
   endtask
   // copy start when s is high, copy end otherwise
   task automatic pulse(input logic s);
      cst <= s;
      cen <= !s;
      @(posedge clk);
      cst <= 1'b0;
      cen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask
   initial begin
      do_reset();
      ck(2'h0, 1'b0, 8'h05);
      cmp({rsp.grant, rsp.rdata}, {1'b1, 8'h05 ^ 8'ha5});
      av(1'b1, 8'h40, 8'h12);
      av(1'b0, 8'h40, 8'h00);
      cmp(q, 32'h0);
      cmp(segp, 8'h00);
      ck(2'h0, 1'b0, 8'h38);
      cmp({rsp.grant, rsp.rdata}, {1'b0, 8'h00});
      av(1'b1, 8'h20, 8'h01);
      av(1'b1, 8'h60, 8'h0c);
      cmp(ssz, 8'h0c);
      ck(2'h0, 1'b0, 8'h10);
      cmp(rsp.grant, 1'b0);
      av(1'b1, 8'h20, 8'h03);
      cmp(mode, sfw_pkg::SFW_SYS);
      av(1'b1, 8'h40, 8'h12);
      av(1'b0, 8'h40, 8'h00);
      cmp(q, 32'h12);
      av(1'b1, 8'h21, 8'h77);
      av(1'b0, 8'h21, 8'h00);
      cmp(q, 32'h0);
      av(1'b1, 8'h52, 8'h34);
      cmp(xb, 8'h34);
      av(1'b1, 8'h53, 8'h21);
      cmp(xsz, 8'h21);
      ck(2'h0, 1'b1, 8'h31);
      cmp(rsp.we, 1'b0);
      ck(2'h0, 1'b0, 8'h10);
      cmp({rsp.grant, rsp.rdata}, {1'b1, 8'h10 ^ 8'ha5});
      ck(2'h2, 1'b0, 8'h05);
      cmp(rsp.grant, 1'b0);
      pulse(1'b1);
      av(1'b1, 8'h20, 8'h04);
      cmp(mode, sfw_pkg::SFW_USER);
      ck(2'h1, 1'b0, 8'h40);
      cmp(rsp.grant, 1'b1);
      pulse(1'b0);
      ck(2'h1, 1'b0, 8'h40);
      cmp(rsp.grant, 1'b0);
      ck(2'h0, 1'b0, 8'h40);
      cmp(rsp.grant, 1'b0);
      av(1'b1, 8'h40, 8'h99);
      cmp(segp, 8'h12);
      av(1'b0, 8'h20, 8'h00);
      cmp(q, 32'h4);
      ck(2'h0, 1'b0, 8'h10);
      cmp(rsp.grant, 1'b1);
      ev('{exc: 1'b1, default: '0});
      cmp(mode === sfw_pkg::SFW_USER, 1'b0);
      ev('{return_from_interrupt: 1'b1, default: '0});
      cmp(mode, sfw_pkg::SFW_USER);
      do_reset();
      ev('{call: 1'b1, call_code: 3'h3, default: '0});
      cmp(mode, sfw_pkg::SFW_SYS);
      av(1'b1, 8'h54, 8'h01);
      ev('{firmware_entry_vector: 1'b1, default: '0});
      cmp(mode, sfw_pkg::SFW_FW);
      cmp(fok, 1'b1);
      ck(2'h0, 1'b0, 8'h30);
      cmp(rsp.grant, 1'b1);
      ck(2'h0, 1'b0, 8'h60);
      cmp(rsp.grant, 1'b1);
      av(1'b1, 8'h50, 8'hff);
      av(1'b0, 8'h50, 8'h00);
      cmp(q, 32'h0);
      av(1'b1, 8'h52, 8'h55);
      cmp(xb, 8'h00);
      av(1'b0, 8'h20, 8'h00);
      cmp(q, 32'h2);
      ck(2'h0, 1'b0, 8'h10);
      cmp(rsp.grant, 1'b0);
      ck(2'h0, 1'b0, 8'h38);
      cmp(rsp.rdata, 8'h00);
      wrap_up();
   end
endmodule
